// *** verilog/loopback_cfg.svh ***
`ifndef LOOPBACK_CFG_SVH
`define LOOPBACK_CFG_SVH

// Register byte offsets
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_ERR_COUNT 12'h008
`define REG_IRQ_STATUS 12'h00c
`define REG_IRQ_MASK 12'h010

// Control register bits (write one to act)
`define CTRL_START 0
`define CTRL_STOP 1
`define CTRL_ERR_INSERT 2
`define CTRL_ERR_CLEAR 3

// Status register bits
`define STAT_SYNCED 0
`define STAT_ALIGNED 1
`define STAT_TX_ACTIVE 2
`define STAT_RX_VALID 3
`define STAT_MATCH 4
`define STAT_ERR_FLAG 5

// Interrupt status and mask bits
`define IRQ_W 3
`define IRQ_ERROR 0
`define IRQ_RX_VALID 1
`define IRQ_ALIGN_LOST 2
`define IRQ_MASK_RESET 3'h0

// Character codes on the parallel side of the link
`define CHAR_IDLE 8'h07
`define CHAR_START 8'hfb
`define CHAR_TERM 8'hfd
`define CHAR_PREAMBLE 8'h55
`define CHAR_SFD 8'hd5
`define CTRL_ALL 8'hff
`define CTRL_START_LANE 8'h01
`define CTRL_NONE 8'h00

// Packet shape, in 64-bit words
`define PAYLOAD_WORDS 8
`define GAP_WORDS 12

`endif

// *** verilog/loopback_pkg.sv ***
package loopback_pkg;

  typedef struct packed {
    logic [63:0] data;
    logic [7:0] ctrl;
  } xgmii_word_type;

  typedef enum logic {
    CTL_IDLE = 1'b0,
    CTL_RUN = 1'b1
  } ctl_state_type;

  typedef enum logic [1:0] {
    GEN_GAP = 2'b00,
    GEN_START = 2'b01,
    GEN_PAYLOAD = 2'b11,
    GEN_TERM = 2'b10
  } gen_state_type;

  typedef enum logic [1:0] {
    DET_SEARCH = 2'b00,
    DET_ONE = 2'b01,
    DET_VALID = 2'b11
  } det_state_type;

  typedef struct packed {
    logic start;
    logic stop;
    logic err_insert;
  } button_type;

endpackage : loopback_pkg

// *** verilog/xgmii_packet_loopback_tester.sv ***
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "loopback_cfg.svh"

module xgmii_packet_loopback_tester #(
  parameter int PAYLOAD_WORDS = `PAYLOAD_WORDS,
  parameter int GAP_WORDS = `GAP_WORDS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output loopback_pkg::xgmii_word_type tx_word,
  input wire loopback_pkg::xgmii_word_type rx_word,
  input wire logic [3:0] lane_sync,
  input wire logic lanes_aligned,
  input wire logic start_button,
  input wire logic stop_button,
  input wire logic err_insert_button,
  output logic lanes_synced_indicator,
  output logic lanes_aligned_indicator,
  output logic rx_valid_indicator,
  output logic tx_active_indicator,
  output logic match_indicator,
  output logic error_indicator
);

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic align1;
    logic align2;
    loopback_pkg::button_type btn1;
    loopback_pkg::button_type btn2;
    loopback_pkg::button_type btn3;
    loopback_pkg::ctl_state_type ctl;
    loopback_pkg::gen_state_type gen;
    logic [7:0] gen_cnt;
    logic [7:0] pay_cnt;
    logic ins_armed;
    loopback_pkg::xgmii_word_type tx;
    loopback_pkg::xgmii_word_type rx_q;
    loopback_pkg::det_state_type det;
    logic rx_in_pkt;
    logic [7:0] exp_cnt;
    logic exp_seeded;
    logic checked;
    logic match;
    logic err_flag;
    logic [31:0] err_cnt;
    logic synced_led;
    logic aligned_led;
    logic rx_valid_led;
    logic tx_active_led;
    logic [`IRQ_W-1:0] irq_status;
    logic [`IRQ_W-1:0] irq_mask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_type;

  function automatic loopback_pkg::xgmii_word_type char_word(input logic [7:0] lane0,
                                                             input logic [7:0] rest,
                                                             input logic [7:0] ctrl);
    loopback_pkg::xgmii_word_type w;
    w.data = {{7{rest}}, lane0};
    w.ctrl = ctrl;
    return w;
  endfunction : char_word

  function automatic loopback_pkg::xgmii_word_type idle_word();
    return char_word(`CHAR_IDLE, `CHAR_IDLE, `CTRL_ALL);
  endfunction : idle_word

  // Start character in lane 0, preamble, then the frame delimiter in lane 7
  function automatic loopback_pkg::xgmii_word_type start_word();
    loopback_pkg::xgmii_word_type w;
    w.data = {`CHAR_SFD, {6{`CHAR_PREAMBLE}}, `CHAR_START};
    w.ctrl = `CTRL_START_LANE;
    return w;
  endfunction : start_word

  // Shared by the transmit and the expected generator, so both agree exactly
  function automatic logic [63:0] payload_data(input logic [7:0] cnt);
    return {8{cnt}};
  endfunction : payload_data

  // Saturates so that a long burst never wraps back to a small count
  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    return (&v) ? v : v + 32'h1;
  endfunction : sat_inc

  function automatic state_type reset_value();
    state_type r;
    r = '0;
    r.tx = idle_word();
    r.irq_mask = `IRQ_MASK_RESET;
    return r;
  endfunction : reset_value

  localparam state_type RESET_STATE = reset_value();
  localparam logic [7:0] GAP_LAST = 8'(GAP_WORDS - 1);
  localparam logic [7:0] PAYLOAD_LAST = 8'(PAYLOAD_WORDS - 1);

  state_type st;
  state_type next_st;

  always_comb begin
    logic setup;
    logic wr;
    logic mapped;
    logic [31:0] rd;
    logic [31:0] wdata;
    logic [`IRQ_W-1:0] irq_set;
    logic [`IRQ_W-1:0] irq_clr;
    loopback_pkg::button_type press;
    logic sw_start;
    logic sw_stop;
    logic sw_ins;
    logic sw_clr;
    logic lanes_ready;
    logic is_start;
    logic is_payload;
    logic err_event;
    setup = 1'b0;
    wr = 1'b0;
    mapped = 1'b0;
    rd = 32'h0;
    wdata = pwdata;
    irq_set = '0;
    irq_clr = '0;
    press = '0;
    sw_start = 1'b0;
    sw_stop = 1'b0;
    sw_ins = 1'b0;
    sw_clr = 1'b0;
    lanes_ready = 1'b0;
    is_start = 1'b0;
    is_payload = 1'b0;
    err_event = 1'b0;
    next_st = st;

    // Pins from outside the clock domain pass two flops before use
    next_st.sync1 = lane_sync;
    next_st.sync2 = st.sync1;
    next_st.align1 = lanes_aligned;
    next_st.align2 = st.align1;
    next_st.btn1 = '{start: start_button, stop: stop_button, err_insert: err_insert_button};
    next_st.btn2 = st.btn1;
    next_st.btn3 = st.btn2;
    // Buttons act on the rising edge only; holding one down does not repeat it
    press = st.btn2 & ~st.btn3;

    // Register bus: answer in the access cycle that follows every setup taken with the clock enable high
    // Read data is taken at setup; the master holds the address through the access
    // Unmapped or unaligned offsets answer with an error, read zero and ignore writes
    setup = psel && !penable;
    wr = psel && penable && st.pready && pwrite;
    mapped = (paddr == `REG_CTRL) || (paddr == `REG_STATUS) || (paddr == `REG_ERR_COUNT) ||
             (paddr == `REG_IRQ_STATUS) || (paddr == `REG_IRQ_MASK);
    unique case (paddr)
      `REG_STATUS: begin
        rd[`STAT_SYNCED] = st.synced_led;
        rd[`STAT_ALIGNED] = st.aligned_led;
        rd[`STAT_TX_ACTIVE] = st.tx_active_led;
        rd[`STAT_RX_VALID] = st.rx_valid_led;
        rd[`STAT_MATCH] = st.match;
        rd[`STAT_ERR_FLAG] = st.err_flag;
      end
      `REG_ERR_COUNT: rd = st.err_cnt;
      `REG_IRQ_STATUS: rd[`IRQ_W-1:0] = st.irq_status;
      `REG_IRQ_MASK: rd[`IRQ_W-1:0] = st.irq_mask;
      default: rd = 32'h0;
    endcase
    next_st.pready = setup;
    next_st.pslverr = setup && !mapped;
    next_st.prdata = (setup && !pwrite) ? rd : 32'h0;
    if (wr && paddr == `REG_CTRL) begin
      sw_start = wdata[`CTRL_START];
      sw_stop = wdata[`CTRL_STOP];
      sw_ins = wdata[`CTRL_ERR_INSERT];
      sw_clr = wdata[`CTRL_ERR_CLEAR];
    end
    if (wr && paddr == `REG_IRQ_STATUS) begin
      irq_clr = wdata[`IRQ_W-1:0];
    end
    if (wr && paddr == `REG_IRQ_MASK) begin
      next_st.irq_mask = wdata[`IRQ_W-1:0];
    end

    // Control block
    next_st.synced_led = &st.sync2;
    next_st.aligned_led = st.align2;
    lanes_ready = (&st.sync2) && st.align2;
    unique case (st.ctl)
      loopback_pkg::CTL_IDLE: begin
        if ((press.start || sw_start) && lanes_ready) begin
          next_st.ctl = loopback_pkg::CTL_RUN;
        end
      end
      loopback_pkg::CTL_RUN: begin
        // Losing alignment stops the test rather than sending into a broken link
        if (press.stop || sw_stop || !st.align2) begin
          next_st.ctl = loopback_pkg::CTL_IDLE;
        end
      end
    endcase
    next_st.tx_active_led = (next_st.ctl == loopback_pkg::CTL_RUN);
    // The aligned indicator lags by one flop, so loss of alignment is a one-cycle event
    if (st.align2 == 1'b0 && st.aligned_led == 1'b1) begin
      irq_set[`IRQ_ALIGN_LOST] = 1'b1;
    end

    // Transmit generator
    if (press.err_insert || sw_ins) begin
      next_st.ins_armed = 1'b1;
    end
    if (st.ctl != loopback_pkg::CTL_RUN) begin
      next_st.gen = loopback_pkg::GEN_GAP;
      next_st.gen_cnt = 8'h0;
      next_st.tx = idle_word();
    end else begin
      unique case (st.gen)
        loopback_pkg::GEN_GAP: begin
          next_st.tx = idle_word();
          // Counter restarts at zero on entry, so every gap has the same length
          if (st.gen_cnt >= GAP_LAST) begin
            next_st.gen = loopback_pkg::GEN_START;
            next_st.gen_cnt = 8'h0;
          end else begin
            next_st.gen_cnt = st.gen_cnt + 8'h1;
          end
        end
        loopback_pkg::GEN_START: begin
          next_st.tx = start_word();
          next_st.gen = loopback_pkg::GEN_PAYLOAD;
        end
        loopback_pkg::GEN_PAYLOAD: begin
          next_st.tx.data = payload_data(st.pay_cnt);
          next_st.tx.ctrl = `CTRL_NONE;
          if (st.ins_armed) begin
            next_st.tx.data[0] = ~next_st.tx.data[0];
            // A request landing on the flip cycle stays armed for the next word
            next_st.ins_armed = press.err_insert || sw_ins;
          end
          // Runs on across packets and stops, so the receiver can lock onto any phase
          next_st.pay_cnt = st.pay_cnt + 8'h1;
          if (st.gen_cnt >= PAYLOAD_LAST) begin
            next_st.gen = loopback_pkg::GEN_TERM;
            next_st.gen_cnt = 8'h0;
          end else begin
            next_st.gen_cnt = st.gen_cnt + 8'h1;
          end
        end
        loopback_pkg::GEN_TERM: begin
          // Terminate in lane 0, idle in the other seven
          next_st.tx = char_word(`CHAR_TERM, `CHAR_IDLE, `CTRL_ALL);
          next_st.gen = loopback_pkg::GEN_GAP;
        end
      endcase
    end

    // Receive side: the transceiver word shares this clock, one pipeline stage
    next_st.rx_q = rx_word;
    is_start = (st.rx_q == start_word());
    is_payload = st.rx_in_pkt && (st.rx_q.ctrl == `CTRL_NONE);
    // Any control character ends a packet, so a cut frame never runs into the next
    if (is_start) begin
      next_st.rx_in_pkt = 1'b1;
    end else if (st.rx_q.ctrl != `CTRL_NONE) begin
      next_st.rx_in_pkt = 1'b0;
    end
    unique case (st.det)
      loopback_pkg::DET_SEARCH: begin
        if (is_start) begin
          next_st.det = loopback_pkg::DET_ONE;
        end
      end
      loopback_pkg::DET_ONE: begin
        if (is_start) begin
          next_st.det = loopback_pkg::DET_VALID;
          irq_set[`IRQ_RX_VALID] = 1'b1;
        end
      end
      loopback_pkg::DET_VALID: begin
        next_st.det = loopback_pkg::DET_VALID;
      end
      default: begin
        next_st.det = loopback_pkg::DET_SEARCH;
      end
    endcase
    next_st.rx_valid_led = (next_st.det == loopback_pkg::DET_VALID);

    // Expected generator and comparator
    // A word lost by the link shifts the phase, and every later word then fails
    next_st.checked = 1'b0;
    if (st.det == loopback_pkg::DET_VALID && is_payload) begin
      if (!st.exp_seeded) begin
        // The first payload word after valid sets the phase; it is not checked
        next_st.exp_seeded = 1'b1;
        next_st.exp_cnt = st.rx_q.data[7:0] + 8'h1;
      end else begin
        next_st.checked = 1'b1;
        next_st.match = (st.rx_q.data == payload_data(st.exp_cnt));
        next_st.exp_cnt = st.exp_cnt + 8'h1;
      end
    end

    // Error flag and counter; a fresh error wins over a software clear
    err_event = st.checked && !st.match && st.rx_valid_led;
    if (sw_clr) begin
      next_st.err_flag = 1'b0;
      next_st.err_cnt = 32'h0;
    end
    if (err_event) begin
      next_st.err_flag = 1'b1;
      next_st.err_cnt = sw_clr ? 32'h1 : sat_inc(st.err_cnt);
      irq_set[`IRQ_ERROR] = 1'b1;
    end

    // Sticky interrupt bits, write one to clear, set beats clear
    next_st.irq_status = (st.irq_status & ~irq_clr) | irq_set;
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);
  end

  // A low clock enable also holds the bus answer; a setup or write edge that falls while it is low is missed, not delayed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= RESET_STATE;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // Every output is a field of the state register, so none has a logic path
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign irq = st.irq;
  assign tx_word = st.tx;
  assign lanes_synced_indicator = st.synced_led;
  assign lanes_aligned_indicator = st.aligned_led;
  assign rx_valid_indicator = st.rx_valid_led;
  assign tx_active_indicator = st.tx_active_led;
  assign match_indicator = st.match;
  assign error_indicator = st.err_flag;

endmodule : xgmii_packet_loopback_tester

// *** test/loopback_partner.sv ***
`timescale 1ns/1ps
module loopback_partner #(
  parameter int LAT = 3
) (
  input wire logic pclk,
  input wire logic link_up,
  input wire loopback_pkg::xgmii_word_type tx_word,
  output loopback_pkg::xgmii_word_type rx_word,
  output logic [3:0] lane_sync,
  output logic lanes_aligned
);
  loopback_pkg::xgmii_word_type pipe [LAT];
  initial begin
    lane_sync = 4'h0;
    lanes_aligned = 1'b0;
    rx_word = 72'h0;
    for (int i = 0; i < LAT; i++) pipe[i] = 72'h0;
  end
  // Lanes lock one at a time; alignment only once all are locked
  always @(posedge pclk) begin
    lane_sync <= link_up ? {lane_sync[2:0], 1'b1} : 4'h0;
    lanes_aligned <= link_up && (&lane_sync);
    pipe[0] <= tx_word;
    for (int i = 1; i < LAT; i++) pipe[i] <= pipe[i-1];
    // Unlocked receiver delivers garbage, not a stale copy
    rx_word <= link_up ? pipe[LAT-1] : ~pipe[LAT-1];
  end
endmodule : loopback_partner

// *** test/tester_monitor.sv ***
`timescale 1ns/1ps
module tester_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire loopback_pkg::xgmii_word_type tx_word,
  input wire loopback_pkg::xgmii_word_type rx_word,
  input wire logic [3:0] lane_sync,
  input wire logic lanes_aligned,
  input wire logic lanes_synced_indicator,
  input wire logic lanes_aligned_indicator,
  input wire logic rx_valid_indicator,
  input wire logic tx_active_indicator,
  input wire logic match_indicator,
  input wire logic error_indicator
);
  localparam logic [71:0] START = {8'hd5, {6{8'h55}}, 8'hfb, 8'h01};
  localparam logic [71:0] TERM = {{7{8'h07}}, 8'hfd, 8'hff};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic idle_w;
  assign idle_w = tx_word == {{8{8'h07}}, 8'hff};
  a_idle_when_off: assert property (
    !tx_active_indicator && $past(!tx_active_indicator) |-> idle_w) else $error("tx not idle");
  a_ctrl_legal: assert property (
    tx_word.ctrl inside {8'hff, 8'h01, 8'h00} && (tx_word.ctrl != 8'h01 || tx_word == START))
    else $error("bad control vector");
  a_start_then_data: assert property (
    tx_word == START |=> tx_word.ctrl == 8'h00 || !tx_active_indicator) else $error("no payload");
  a_payload_count: assert property (
    tx_word.ctrl == 8'h00 && $past(tx_word.ctrl) == 8'h00
    |-> tx_word.data[15:8] == $past(tx_word.data[15:8]) + 8'h01) else $error("count skipped");
  a_term_then_gap: assert property (
    tx_word == TERM |=> idle_w) else $error("no gap after terminate");
  a_lane_status: assert property (
    $past(presetn, 3) |-> lanes_synced_indicator == $past(&lane_sync, 3)
    && lanes_aligned_indicator == $past(lanes_aligned, 3)) else $error("lane indicators wrong");
  a_start_gated: assert property (
    $rose(tx_active_indicator) |-> $past(lanes_aligned, 3) && $past(&lane_sync, 3))
    else $error("started while lanes not ready");
  a_valid_after_start: assert property (
    $rose(rx_valid_indicator) |-> $past(rx_word, 2) == START || $past(rx_word, 3) == START)
    else $error("valid without start pattern");
  a_valid_sticky: assert property (
    rx_valid_indicator |=> rx_valid_indicator) else $error("valid dropped");
  a_error_cause: assert property (
    $rose(error_indicator) |-> !$past(match_indicator) && rx_valid_indicator)
    else $error("error flag without mismatch");
  c_tx_run: cover property ($rose(tx_active_indicator));
  c_rx_valid: cover property ($rose(rx_valid_indicator));
  c_error: cover property ($rose(error_indicator));
endmodule : tester_monitor
bind xgmii_packet_loopback_tester tester_monitor i_tester_monitor (.pclk, .presetn, .tx_word,
  .rx_word, .lane_sync, .lanes_aligned, .lanes_synced_indicator, .lanes_aligned_indicator,
  .rx_valid_indicator, .tx_active_indicator, .match_indicator, .error_indicator);

// *** test/tb_xgmii_packet_loopback_tester.sv ***
`timescale 1ns/1ps
`include "loopback_cfg.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_xgmii_packet_loopback_tester;
  localparam int PAY = 4;
  localparam int GAP = 3;
  localparam logic [71:0] IDLE = {{8{8'h07}}, 8'hff};
  localparam logic [71:0] START = {8'hd5, {6{8'h55}}, 8'hfb, 8'h01};
  localparam logic [71:0] TERM = {{7{8'h07}}, 8'hfd, 8'hff};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, err, lanes_aligned;
  logic link_up = 1'b0;
  logic clk_en = 1'b1;
  // Buttons: start, stop, error insert
  logic [2:0] btn = 3'h0;
  loopback_pkg::xgmii_word_type tx_word, rx_word;
  logic [3:0] lane_sync;
  logic lanes_synced_indicator, lanes_aligned_indicator, rx_valid_indicator;
  logic tx_active_indicator, match_indicator, error_indicator;
  int error_cnt = 0;
  int cmp_count = 0;
  int npay = 0;
  int nidle = 0;
  int n;
  logic [7:0] starts = 8'h00;
  logic seen = 1'b0;
  always #5 pclk = ~pclk;
  xgmii_packet_loopback_tester #(.PAYLOAD_WORDS(PAY), .GAP_WORDS(GAP))
    i_xgmii_packet_loopback_tester (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .tx_word, .rx_word, .lane_sync,
    .lanes_aligned, .start_button(btn[0]), .stop_button(btn[1]), .err_insert_button(btn[2]),
    .lanes_synced_indicator, .lanes_aligned_indicator, .rx_valid_indicator,
    .tx_active_indicator, .match_indicator, .error_indicator);
  // Slow loop so several words are in flight
  loopback_partner #(.LAT(5)) i_loopback_partner (.pclk, .link_up, .tx_word, .rx_word,
    .lane_sync, .lanes_aligned);
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
    if (k == 20) error_cnt++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic press(input int b);
    @(posedge pclk);
    btn[b] <= 1'b1;
    repeat (4) @(posedge pclk);
    btn[b] <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : press
  task automatic report_and_stop();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  // Packet shape seen on the transmit side
  always @(posedge pclk) begin
    if (rx_word == START) starts <= starts + 8'h01;
    if (tx_word == TERM) begin
      `CHK(npay, PAY)
      seen = 1'b1;
      nidle = 0;
    end else if (tx_word == START) begin
      if (seen) `CHK(nidle, GAP)
      npay = 0;
    end else if (tx_word.ctrl == 8'h00) npay++;
    else nidle++;
    // A stopped generator starts afresh, so its first gap is not measured
    if (tx_active_indicator !== 1'b1) seen = 1'b0;
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK({tx_word, rx_valid_indicator, tx_active_indicator}, {IDLE, 2'h0})
    apb(1'b0, 12'h014, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    press(0);
    repeat (20) @(posedge pclk);
    `CHK({tx_active_indicator, tx_word}, {1'b0, IDLE})
    link_up <= 1'b1;
    repeat (12) @(posedge pclk);
    apb(1'b0, `REG_STATUS, 32'h0);
    `CHK(rd, 32'h3)
    // A press while the clock enable is low must never reach the state
    clk_en <= 1'b0;
    press(0);
    clk_en <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK(tx_active_indicator, 1'b0)
    press(0);
    `CHK(tx_active_indicator, 1'b1)
    n = 0;
    while (rx_valid_indicator !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    `CHK(rx_valid_indicator, 1'b1)
    `CHK(starts, 8'h02)
    repeat (3 * (PAY + GAP + 2)) @(posedge pclk);
    apb(1'b0, `REG_STATUS, 32'h0);
    `CHK({irq, rd}, 33'h1f)
    apb(1'b1, `REG_IRQ_MASK, 32'h1);
    apb(1'b0, `REG_IRQ_MASK, 32'h0);
    `CHK(rd, 32'h1)
    press(2);
    repeat (40) @(posedge pclk);
    apb(1'b0, `REG_ERR_COUNT, 32'h0);
    `CHK(rd, 32'h1)
    `CHK({irq, error_indicator, match_indicator}, 3'h7)
    apb(1'b0, `REG_IRQ_STATUS, 32'h0);
    `CHK(rd, 32'h3)
    apb(1'b1, `REG_IRQ_STATUS, 32'h1);
    apb(1'b0, `REG_IRQ_STATUS, 32'h0);
    `CHK({irq, rd}, 33'h2)
    apb(1'b1, `REG_CTRL, 32'h4);
    repeat (40) @(posedge pclk);
    apb(1'b0, `REG_ERR_COUNT, 32'h0);
    `CHK(rd, 32'h2)
    apb(1'b1, `REG_CTRL, 32'h8);
    apb(1'b0, `REG_ERR_COUNT, 32'h0);
    `CHK({error_indicator, rd}, 33'h0)
    apb(1'b1, `REG_CTRL, 32'h4);
    repeat (40) @(posedge pclk);
    apb(1'b0, `REG_ERR_COUNT, 32'h0);
    `CHK({error_indicator, rd}, 33'h100000001)
    press(1);
    `CHK({tx_active_indicator, tx_word}, {1'b0, IDLE})
    link_up <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(1'b0, `REG_IRQ_STATUS, 32'h0);
    `CHK(rd[2], 1'b1)
    apb(1'b1, `REG_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    `CHK(tx_active_indicator, 1'b0)
    link_up <= 1'b1;
    repeat (12) @(posedge pclk);
    apb(1'b1, `REG_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    `CHK(tx_active_indicator, 1'b1)
    apb(1'b1, `REG_CTRL, 32'h2);
    repeat (2) @(posedge pclk);
    `CHK({tx_active_indicator, tx_word}, {1'b0, IDLE})
    apb(1'b1, `REG_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    `CHK({error_indicator, rx_valid_indicator, match_indicator}, 3'h0)
    `CHK({tx_active_indicator, tx_word}, {1'b0, IDLE})
    presetn <= 1'b1;
    apb(1'b0, `REG_ERR_COUNT, 32'h0);
    `CHK(rd, 32'h0)
    report_and_stop();
  end
  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end
endmodule : tb_xgmii_packet_loopback_tester
